// >>> core/shutdown_pkg.sv
// package: constants and carrier types for the pwm auto-shutdown and restart block
// ----------------------------------------------------------------------------
// Function
// - restart_enable sits at bit 7 of the pwm delay configuration byte.
// - with restart enabled, flag holds while cause persists, then self-clears.
// - with restart disabled, flag holds until software clears it.
// - after flag clears, outputs stay shut until the next period boundary.
// - software writes to the flag are ignored while a shutdown cause is active.
// - comparator causes are levels; flag never clears while they persist.
// - software writing one to the flag forces shutdown.
// - mode control bits 1:0 pick polarity separately for pairs a/c and b/d.
// - period timer flag sets when the second pwm period begins.
// - duty is duty_high_byte plus mode control bits 5:4 as low bits.
// - dead-band delay is delay configuration bits 6:0 in half-bridge mode.
// - in sleep the timer stops and flags and pins freeze, except clock_fail_flag and the raw-cause pin override; duty and dead-band captures still update.
// - primary idle keeps running; other power modes clock the timer from their clock.
// - clock failure with monitor enabled sets clock_fail_flag; internal oscillator clocks.
// - any reset releases all pins to input and restores register reset values.
// - source select: 000 off, 001 cmp1, 010 cmp2, 011 either, bit 2 adds fault.
// - shutdown state 00 drives low, 01 drives high, 1x tri-states the pair.
// - a shutdown event sets the flag and overrides pins asynchronously.
// - flag set at a period start holds shutdown for that whole period.
// ----------------------------------------------------------------------------
package shutdown_pkg;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int          RESTART_BIT     = 7;
  localparam int          DEADBAND_MSB    = 6;
  localparam int          POL_AC_BIT      = 0;
  localparam int          POL_BD_BIT      = 1;
  localparam int          DUTY_LO_MSB     = 5;
  localparam int          DUTY_LO_LSB     = 4;
  localparam int          SRC_FAULT_BIT   = 2;
  localparam int          SRC_CMP2_BIT    = 1;
  localparam int          SRC_CMP1_BIT    = 0;
  localparam int          PSS_TRI_BIT     = 1;
  localparam int          PSS_LVL_BIT     = 0;

  // ----------------------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  DELAY_CFG_RST   = 8'h00;
  localparam logic [7:0]  MODE_CTRL_RST   = 8'h00;
  localparam logic [7:0]  PERIOD_RST      = 8'h00;
  localparam logic [7:0]  DUTY_HI_RST     = 8'h00;
  localparam logic [2:0]  SRC_RST         = 3'h0;
  localparam logic [1:0]  PSS_RST         = 2'h0;
  localparam logic [1:0]  PERIODS_TO_FLAG = 2'h2;
  localparam logic [9:0]  DUTY_ZERO       = 10'h000;
  localparam int          SYNC_DEPTH      = 2;

  // the two pin pairs, each with its own shutdown state and polarity
  typedef struct packed {
    logic [1:0] ac;
    logic [1:0] bd;
  } pss_t;

  // per-pin output bundle: level and enable for a, b, c, d
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } pins_t;

  // synchronised shutdown sources
  typedef struct packed {
    logic fault;
    logic cmp2;
    logic cmp1;
  } src_t;

endpackage : shutdown_pkg

// >>> core/source_sync.sv
// two-stage synchroniser bank for the shutdown source pins
`timescale 1ns/10ps
`default_nettype none
module source_sync
  import shutdown_pkg::*;
(
  input  wire logic ref_clk,  // module clock
  input  wire logic sys_rst,  // synchronous reset, active high
  input  wire src_t raw,      // asynchronous source levels
  output var  src_t synced    // levels after two flops
);

  // state of the module: both stages, first stage read only by the second
  typedef struct packed {
    src_t s1;
    src_t s2;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  // shift one stage per clock
  always_comb begin
    st_d    = st_q;
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign synced = st_q.s2;

endmodule : source_sync
`default_nettype wire

// >>> core/pwm_auto_shutdown_restart.sv
// pwm output stage with auto-shutdown, automatic restart and start-up sequencing
`timescale 1ns/10ps
`default_nettype none
module pwm_auto_shutdown_restart
  import shutdown_pkg::*;
(
  input  wire logic       ref_clk,             // primary or power-managed clock
  input  wire logic       sys_rst,             // synchronous reset, active high
  input  wire logic       sleep_mode,          // high while the device sleeps
  input  wire logic       clock_fail_detect,   // primary clock failure detected
  input  wire logic       fail_safe_enable,    // fail-safe monitor enabled
  input  wire logic       clock_fail_clear,    // software clears clock_fail_flag
  input  wire logic       fault_input,         // fault pin, asynchronous
  input  wire logic       cmp1_out,            // comparator 1 output, asynchronous
  input  wire logic       cmp2_out,            // comparator 2 output, asynchronous
  input  wire logic [7:0] pwm_delay_config,    // restart_enable and dead-band count
  input  wire logic [7:0] mode_control,        // duty low bits and polarity select
  input  wire logic [7:0] duty_high_byte,      // duty upper eight bits
  input  wire logic [7:0] period_value,        // period compare value
  input  wire logic       timer_run,           // period timer run
  input  wire logic [1:0] timer_prescale,      // 1, 4 or 16 prescale
  input  wire logic       timer_flag_clear,    // software clears period_timer_flag
  input  wire logic [2:0] shutdown_source_select, // shutdown source choice
  input  wire pss_t       shutdown_state,      // per-pair shutdown states
  input  wire logic       flag_write,          // software write strobe to status flag
  input  wire logic       flag_wdata,          // value written to status flag
  input  wire logic [3:0] pin_direction,       // 1 = input, 0 = output; a,b,c,d
  output var  logic       shutdown_status_flag,// shutdown flag, registered
  output var  logic       period_timer_flag,   // second period started, sticky
  output var  logic       clock_fail_flag,     // clock failure seen, sticky
  output var  logic       shutdown_active,     // outputs held in shutdown
  output var  logic [9:0] duty_value,          // assembled duty cycle
  output var  logic [6:0] deadband_count,      // dead-band delay count
  output var  pins_t      pins                 // pin levels and enables
);

  // ----------------------------------------------------------------------------
  // synchronised shutdown sources
  // ----------------------------------------------------------------------------
  src_t raw_src;
  src_t sync_src;

  assign raw_src = '{fault: fault_input, cmp2: cmp2_out, cmp1: cmp1_out};

  source_sync u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .raw     (raw_src),
    .synced  (sync_src)
  );

  // selects the sources that count as a shutdown cause
  function automatic logic cause_of(input logic [2:0] sel, input src_t s);
    cause_of = (sel[SRC_CMP1_BIT]  & s.cmp1) |
               (sel[SRC_CMP2_BIT]  & s.cmp2) |
               (sel[SRC_FAULT_BIT] & s.fault);
  endfunction : cause_of

  // maps a two-bit shutdown state to {enable, level}
  function automatic logic [1:0] pss_drive(input logic [1:0] pss);
    pss_drive = {~pss[PSS_TRI_BIT], pss[PSS_LVL_BIT]};
  endfunction : pss_drive

  // ----------------------------------------------------------------------------
  // module state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic        flag;
    logic        hold;        // outputs held for the current period
    logic        tmr_flag;
    logic        cfail;
    logic [1:0]  periods;     // period starts seen since reset, capped at two
    logic [7:0]  timer;
    logic [3:0]  pre;
    logic        pwm_raw;
    pins_t       pins;
    logic [9:0]  duty;
    logic [6:0]  dband;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic       cause;
  logic       restart;
  logic       prescale_done;
  logic [3:0] pre_max;
  logic       period_start;
  logic [9:0] duty_cmp;
  logic       shut_now;
  logic [1:0] drv_ac;
  logic [1:0] drv_bd;

  assign cause   = cause_of(shutdown_source_select, sync_src);
  assign restart = pwm_delay_config[RESTART_BIT];
  assign drv_ac  = pss_drive(shutdown_state.ac);
  assign drv_bd  = pss_drive(shutdown_state.bd);

  // prescale terminal count: 00 -> 1, 01 -> 4, 1x -> 16
  always_comb begin
    case (timer_prescale)
      2'h0:    pre_max = 4'h0;
      2'h1:    pre_max = 4'h3;
      default: pre_max = 4'hF;
    endcase
  end

  assign prescale_done = (st_q.pre == pre_max);
  assign period_start  = timer_run && !sleep_mode && prescale_done &&
                         (st_q.timer == period_value);
  assign duty_cmp      = {duty_high_byte, mode_control[DUTY_LO_MSB:DUTY_LO_LSB]};

  // ----------------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.duty  = duty_cmp;
    st_d.dband = pwm_delay_config[DEADBAND_MSB:0];

    // sleep freezes everything below except the clock-fail flag: timer, flags, pins
    if (!sleep_mode) begin
      // period timer; counts on whatever clock feeds ref_clk
      if (timer_run) begin
        st_d.pre = prescale_done ? 4'h0 : st_q.pre + 4'h1;
        if (prescale_done) begin
          st_d.timer = (st_q.timer == period_value) ? 8'h00 : st_q.timer + 8'h01;
        end
      end

      // count period starts; the second one raises the timer flag
      if (timer_flag_clear) begin
        st_d.tmr_flag = 1'b0;
      end
      if (period_start) begin
        if (st_q.periods != PERIODS_TO_FLAG) begin
          st_d.periods = st_q.periods + 2'h1;
        end
        if (st_q.periods == PERIODS_TO_FLAG - 2'h1) begin
          st_d.tmr_flag = 1'b1;
        end
      end

      // pwm waveform: high while timer times four is below duty (all ten duty bits vs {timer, 00})
      st_d.pwm_raw = ({st_q.timer, 2'h0} < duty_cmp) && (duty_cmp != DUTY_ZERO);

      // shutdown status flag; a cause always wins over a clear, a write beats the self-clear
      if (flag_write && !cause) begin
        st_d.flag = flag_wdata;
      end
      if (cause) begin
        st_d.flag = 1'b1;
      end else if (restart && st_q.flag && !flag_write) begin
        st_d.flag = 1'b0;
      end                                                  // else held

      // hold covers whole periods; release only at a boundary after the flag has dropped,
      // so a clear that lands on a boundary still waits for the next one
      if (st_d.flag) begin
        st_d.hold = 1'b1;
      end else if (period_start && !st_q.flag) begin
        st_d.hold = 1'b0;
      end
    end

    // clock failure runs on the backup oscillator, so it is caught even in sleep
    if (clock_fail_clear) begin
      st_d.cfail = 1'b0;
    end
    if (clock_fail_detect && fail_safe_enable) begin
      st_d.cfail = 1'b1;
    end

    // registered pin drive with polarity per pair
    if (!sleep_mode) begin
      st_d.pins.level[0] = st_q.pwm_raw ^ mode_control[POL_AC_BIT];
      st_d.pins.level[2] = st_q.pwm_raw ^ mode_control[POL_AC_BIT];
      st_d.pins.level[1] = st_q.pwm_raw ^ mode_control[POL_BD_BIT];
      st_d.pins.level[3] = st_q.pwm_raw ^ mode_control[POL_BD_BIT];
      st_d.pins.oe       = ~pin_direction;
    end
  end

  // ----------------------------------------------------------------------------
  // state register; reset releases all pins to input
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q       <= '0;
      st_q.duty  <= {DUTY_HI_RST, MODE_CTRL_RST[DUTY_LO_MSB:DUTY_LO_LSB]};
      st_q.dband <= DELAY_CFG_RST[DEADBAND_MSB:0];
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs; the override is combinational on raw pins so a fault acts at once,
  // trading a glitch-free pin for the shortest reaction time
  // ----------------------------------------------------------------------------
  assign shut_now = st_q.hold | (cause_of(shutdown_source_select, raw_src) & ~sys_rst);

  always_comb begin
    pins = st_q.pins;
    if (shut_now) begin
      pins.level[0] = drv_ac[0];
      pins.level[2] = drv_ac[0];
      pins.level[1] = drv_bd[0];
      pins.level[3] = drv_bd[0];
      pins.oe[0]    = st_q.pins.oe[0] & drv_ac[1];
      pins.oe[2]    = st_q.pins.oe[2] & drv_ac[1];
      pins.oe[1]    = st_q.pins.oe[1] & drv_bd[1];
      pins.oe[3]    = st_q.pins.oe[3] & drv_bd[1];
    end
  end

  assign shutdown_status_flag = st_q.flag;
  assign period_timer_flag    = st_q.tmr_flag;
  assign clock_fail_flag      = st_q.cfail;
  assign shutdown_active      = st_q.hold;
  assign duty_value           = st_q.duty;
  assign deadband_count       = st_q.dband;

endmodule : pwm_auto_shutdown_restart
`default_nettype wire

// >>> verification/shutdown_assertions.sv
// checker: port-level properties of the shutdown block
`timescale 1ns/10ps
`default_nettype none
module shutdown_assertions
  import shutdown_pkg::*;
(
  input wire logic       ref_clk,                // clock
  input wire logic       sys_rst,                // sync reset
  input wire logic       sleep_mode,             // sleep
  input wire logic       clock_fail_detect,      // clock failure
  input wire logic       fail_safe_enable,       // monitor on
  input wire logic       fault_input,            // fault pin
  input wire logic       cmp1_out,               // comparator 1
  input wire logic [7:0] pwm_delay_config,       // restart and dead-band
  input wire logic [7:0] mode_control,           // duty low, polarity
  input wire logic [7:0] duty_high_byte,         // duty high
  input wire logic [2:0] shutdown_source_select, // sources
  input wire pss_t       shutdown_state,         // pair states
  input wire logic       flag_write,             // flag write strobe
  input wire logic       flag_wdata,             // flag write value
  input wire logic [3:0] pin_direction,          // 1 = input
  input wire logic       shutdown_status_flag,   // flag
  input wire logic       period_timer_flag,      // timer flag
  input wire logic       clock_fail_flag,        // clock fail flag
  input wire logic       shutdown_active,        // outputs held
  input wire logic [9:0] duty_value,             // duty
  input wire logic [6:0] deadband_count,         // dead-band
  input wire pins_t      pins                    // pin bundle
);
  // ----
  // properties
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // guards skip the reset cycles, whose captures load reset values, and the sleep cycles
  property p_duty;
    !$past(sys_rst) && !$past(sleep_mode) |->
      duty_value == {$past(duty_high_byte), $past(mode_control[5:4])};
  endproperty
  property p_dead;
    !$past(sys_rst) && !$past(sleep_mode) |-> deadband_count == $past(pwm_delay_config[6:0]);
  endproperty
  property p_rst;
    disable iff (1'b0) sys_rst |=> pins.oe == 4'h0 && !shutdown_status_flag
      && !period_timer_flag && !clock_fail_flag;
  endproperty
  // a cause seen for three samples has crossed the synchroniser
  property p_cause;
    (cmp1_out && shutdown_source_select[0] && !sleep_mode)[*3] |=> shutdown_status_flag;
  endproperty
  property p_hold;
    shutdown_status_flag && !pwm_delay_config[7] && !flag_write |=> shutdown_status_flag;
  endproperty
  property p_force;
    flag_write && flag_wdata && !sleep_mode |=> shutdown_status_flag;
  endproperty
  property p_held;
    shutdown_status_flag |=> shutdown_active;
  endproperty
  property p_pins;
    // the pin enable register lags direction by one cycle and freezes in sleep
    fault_input && shutdown_source_select[2] && !$past(pin_direction[0]) &&
      !$past(sleep_mode) && !$past(sys_rst) |->
      pins.oe[0] == !shutdown_state.ac[1] && (shutdown_state.ac[1] || pins.level[0] == shutdown_state.ac[0]);
  endproperty
  property p_cfail;
    clock_fail_detect && fail_safe_enable |=> clock_fail_flag;
  endproperty
  a_duty : assert property (p_duty) else $error("duty mismatch");
  a_dead : assert property (p_dead) else $error("dead-band mismatch");
  a_rst : assert property (p_rst) else $error("reset state wrong");
  a_cause : assert property (p_cause) else $error("cause did not set flag");
  a_hold : assert property (p_hold) else $error("flag dropped");
  a_force : assert property (p_force) else $error("forced shutdown missing");
  a_held : assert property (p_held) else $error("outputs released early");
  a_pins : assert property (p_pins) else $error("override pin wrong");
  a_cfail : assert property (p_cfail) else $error("clock fail flag missing");
  c_flag : cover property ($rose(shutdown_status_flag));
  c_timer : cover property ($rose(period_timer_flag));
  c_resume : cover property ($fell(shutdown_active));
endmodule : shutdown_assertions
`default_nettype wire

// >>> verification/bridge_model.sv
// bridge model: pin wires with pull-downs holding the power switches off
`timescale 1ns/10ps
`default_nettype none
module bridge_model
  import shutdown_pkg::*;
(
  input  wire pins_t      pins,     // levels and enables from the block
  output var  logic [3:0] pin_wire  // resolved pin levels
);
  // a released pin falls to its pull-down, so its switch stays off
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_wire[i] = pins.oe[i] ? pins.level[i] : 1'b0;
    end
  end
endmodule : bridge_model
`default_nettype wire

// >>> verification/tb_top.sv
// testbench: start-up, shutdown sources, restart and reset of the shutdown block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import shutdown_pkg::*;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, sleep_mode = 1'b0, clock_fail_detect = 1'b0;
  logic        fail_safe_enable = 1'b0, clock_fail_clear = 1'b0, fault_input = 1'b0;
  logic        cmp1_out = 1'b0, cmp2_out = 1'b0, timer_run = 1'b0, timer_flag_clear = 1'b0;
  logic        flag_write = 1'b0, flag_wdata = 1'b0;
  logic [7:0]  pwm_delay_config = 8'h00, mode_control = 8'h00, duty_high_byte = 8'h00;
  logic [7:0]  period_value = 8'h03;
  logic [1:0]  timer_prescale = 2'h0;
  logic [2:0]  shutdown_source_select = 3'h0; // sources off during setup
  pss_t        shutdown_state = 4'h0;
  logic [3:0]  pin_direction = 4'hF, pin_wire;
  logic        shutdown_status_flag, period_timer_flag, clock_fail_flag, shutdown_active;
  logic [9:0]  duty_value;
  logic [6:0]  deadband_count;
  pins_t       pins, frozen;
  int          bad_count = 0, n_tests = 0, e, act;
  logic [31:0] seed = 32'h7ACD53C0;
  pwm_auto_shutdown_restart pwm_auto_shutdown_restart_inst (.*);
  bridge_model bridge_model_inst (.pins(pins), .pin_wire(pin_wire));
  always #2 ref_clk = ~ref_clk;
  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // settle after the edge so design updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #0.5;
  endtask : step
  task automatic chk(input logic [9:0] got, input int exp);
    n_tests++;
    if (got !== 10'(exp)) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, 10'(exp));
    end
  endtask : chk
  task automatic wr(input logic v);
    @(posedge ref_clk);
    flag_write <= 1'b1;
    flag_wdata <= v;
    @(posedge ref_clk);
    flag_write <= 1'b0;
    #0.5;
  endtask : wr
  task automatic summarize;
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #40000;
    bad_count++;
    summarize();
  end
  // ----
  // main sequence
  // ----
  initial begin
    step(5);
    @(posedge ref_clk) sys_rst <= 1'b0;
    // polarity per pair while the pins are still inputs; idle pwm is low
    @(posedge ref_clk) mode_control <= 8'h01;
    step(2);
    chk(pins.level, 4'h5);
    @(posedge ref_clk) mode_control <= 8'h02;
    step(2);
    chk(pins.level, 4'hA);
    @(posedge ref_clk) mode_control <= 8'h00;
    wr(1'b1);
    chk(shutdown_status_flag, 1);
    chk(period_timer_flag, 0);
    @(posedge ref_clk) timer_flag_clear <= 1'b1;
    @(posedge ref_clk) timer_flag_clear <= 1'b0;
    timer_run <= 1'b1;
    for (int i = 0; i < 40 && period_timer_flag !== 1'b1; i++) step(1);
    chk(period_timer_flag, 1);
    @(posedge ref_clk) pin_direction <= 4'h0;
    wr(1'b0);
    chk({shutdown_status_flag, shutdown_active}, 1);
    for (int i = 0; i < 8 && shutdown_active !== 1'b0; i++) step(1);
    chk(shutdown_active, 0);
    // random duty and dead-band values, compared with the bench's own sums
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      @(posedge ref_clk) duty_high_byte <= seed[7:0];
      mode_control <= {2'h0, seed[9:8], 4'h0};
      pwm_delay_config <= {1'b1, seed[16:10]};
      step(2);
      chk(duty_value, seed[7:0] * 4 + seed[9:8]);
      chk(deadband_count, seed[16:10]);
    end
    // every select code against each single cause, auto restart on
    for (int s = 0; s < 24; s++) begin
      seed = lfsr(seed);
      @(posedge ref_clk) shutdown_source_select <= 3'(s / 3);
      shutdown_state <= seed[3:0];
      {fault_input, cmp2_out, cmp1_out} <= 3'(1 << (s % 3));
      step(4);
      act = ((s / 3) >> (s % 3)) & 1;
      chk(shutdown_status_flag, act);
      e = {seed[1] ? 2'b00 : 2'b11, seed[3] ? 2'b00 : 2'b11};
      if (act == 1) chk(pins.oe, {e[3], e[1], e[2], e[0]});
      if (act == 1) chk(pin_wire, {2{seed[0] && !seed[1], seed[2] && !seed[3]}});
      @(posedge ref_clk) {fault_input, cmp2_out, cmp1_out} <= 3'h0;
      step(3);
      chk(shutdown_status_flag, 0);
      step(6);
    end
    // restart off: flag survives cause removal and ignores early writes
    @(posedge ref_clk) pwm_delay_config <= 8'h00;
    shutdown_source_select <= 3'h1;
    cmp1_out <= 1'b1;
    step(4);
    wr(1'b0);
    chk(shutdown_status_flag, 1);
    @(posedge ref_clk) cmp1_out <= 1'b0;
    step(6);
    chk(shutdown_status_flag, 1);
    wr(1'b0);
    chk({shutdown_status_flag, shutdown_active}, 1);
    // clock failure needs the monitor enabled; clear empties the flag
    @(posedge ref_clk) clock_fail_detect <= 1'b1;
    @(posedge ref_clk) fail_safe_enable <= 1'b1;
    step(0);
    chk(clock_fail_flag, 0);
    @(posedge ref_clk) clock_fail_detect <= 1'b0;
    step(0);
    chk(clock_fail_flag, 1);
    @(posedge ref_clk) clock_fail_clear <= 1'b1;
    @(posedge ref_clk) clock_fail_clear <= 1'b0;
    step(0);
    chk(clock_fail_flag, 0);
    // sleep freezes the pin drive while the timer would have wrapped
    @(posedge ref_clk) sleep_mode <= 1'b1;
    step(2);
    frozen = pins;
    step(12);
    chk(pins, frozen);
    @(posedge ref_clk) sleep_mode <= 1'b0;
    sys_rst <= 1'b1;
    step(1);
    chk({pins.oe, shutdown_status_flag, period_timer_flag, clock_fail_flag}, 0);
    @(posedge ref_clk) sys_rst <= 1'b0;
    step(2);
    summarize();
  end
endmodule : tb_top
bind pwm_auto_shutdown_restart shutdown_assertions shutdown_assertions_inst (.*);
`default_nettype wire
